// [verilog/sar_link_defs.svh]
// Timing and layout constants shared by the converter and its host
`ifndef SAR_LINK_DEFS_SVH
`define SAR_LINK_DEFS_SVH

// Result layout
`define SAR_BITS 12
`define SAR_MSB 11
`define SAR_CORRECT_BIT 2
`define SAR_CORRECT_STEP 12'h008
`define SAR_CORRECT_SPAN 13'h0010

// Clock of both ends
`define CLK_PERIOD_NS 100

// Conversion timing, times in ns, counts in cycles (least times round up)
`define FIRST_DECISION_NS 1500
`define DECISION_STEP_NS 1000
`define BUSY_RISE_NS 13000
`define QUIET_START_NS 8000
`define FIRST_DECISION_CYC \
  ((`FIRST_DECISION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DECISION_STEP_CYC (`DECISION_STEP_NS / `CLK_PERIOD_NS)
`define BUSY_RISE_CYC (`BUSY_RISE_NS / `CLK_PERIOD_NS)
`define QUIET_START_CYC \
  ((`QUIET_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Internal serial clock: half period in cycles
`define SCLK_HALF_CYC 2

// Host start pulse width, well before the quiet window
`define CONVERT_START_N_LOW_NS 1000
`define CONVERT_START_N_LOW_CYC \
  ((`CONVERT_START_N_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Reset values
`define RESULT_RESET 12'h000

`endif

// [verilog/sar_link_pkg.sv]
// Types shared by the converter and its host
package sar_link_pkg;
  typedef logic [11:0] sample_t;
  typedef logic [7:0] convert_start_n_cnt_t;
  typedef logic [3:0] bit_idx_t;
  typedef enum logic [0:0] {CONVERT_START_N_IDLE, CONVERT_START_N_RUN} convert_start_n_state_e;
  typedef enum logic [1:0] {HOST_IDLE, HOST_PULSE, HOST_WAIT} host_state_e;
endpackage

// [verilog/sar_link_if.sv]
// Pins between the converter and its serial host
`timescale 1ns/1ps
interface sar_link_if;
  logic convert_start_n;
  logic external_shift_clock;
  logic clock_source_select;
  logic busy;
  logic serial_clock;
  logic serial_result_out;

  modport converter (
    input convert_start_n,
    input external_shift_clock,
    input clock_source_select,
    output busy,
    output serial_clock,
    output serial_result_out
  );

  modport host (
    output convert_start_n,
    output external_shift_clock,
    output clock_source_select,
    input busy,
    input serial_clock,
    input serial_result_out
  );
endinterface

// [verilog/sar_converter.sv]
// Converter end: conversion sequencer and master-mode serial output
// What this block does
// (R1) Twelve decisions, most significant bit first
// (R2) Set trial bit, clear if above input
// (R3) Limited correction only at tenth decision
// (R4) Tenth decision about 10 to 11 us
// (R5) Host keeps inputs still 8 us to busy
// (R6) Host may raise start line early
// (R7) Busy low converting; shifts previous result out
// (R8) Host is slave, busy selects, 12 bits
// (R9) Internal serial clock idles low
// (R10) Start may come from any trigger source
// (R11) Select high slave, low master mode; select high here shifts nothing out
// (R12) Start falling edge when powered, busy rises
`timescale 1ns/1ps
`include "sar_link_defs.svh"
module sar_converter (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link pins
  sar_link_if.converter link,
  // Analog side, modelled as a held code
  input wire sar_link_pkg::sample_t analog_level,
  input wire logic power_down,
  input wire logic decision_upset,
  // Results
  output sar_link_pkg::sample_t result,
  output logic result_valid,
  output logic link_disturbed,
  output logic converting
);

  // Pin synchronisers: {select, shift clock, start}
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;

  // Sequencer state
  sar_link_pkg::convert_start_n_state_e state_ff, nxt_state;
  sar_link_pkg::convert_start_n_cnt_t cyc_ff, nxt_cyc;
  sar_link_pkg::convert_start_n_cnt_t step_ff, nxt_step;
  sar_link_pkg::bit_idx_t idx_ff, nxt_idx;
  logic deciding_ff, nxt_deciding;
  sar_link_pkg::sample_t sar_ff, nxt_sar;
  sar_link_pkg::sample_t sample_ff, nxt_sample;
  sar_link_pkg::sample_t result_ff, nxt_result;
  logic busy_ff, nxt_busy;
  logic valid_ff, nxt_valid;
  logic disturbed_ff, nxt_disturbed;
  logic convert_start_n_ff, nxt_convert_start_n;

  // Shifter state
  sar_link_pkg::sample_t shift_ff, nxt_shift;
  sar_link_pkg::bit_idx_t left_ff, nxt_left;
  logic [1:0] phase_ff, nxt_phase;
  logic sclk_ff, nxt_sclk;
  logic sdo_ff, nxt_sdo;

  // Decoded helpers
  logic start_edge;
  logic start_moved;
  logic xclk_moved;
  logic master_mode;
  logic in_quiet;
  sar_link_pkg::sample_t mask;
  sar_link_pkg::sample_t base;
  sar_link_pkg::sample_t trial;
  logic keep;

  // Only the second and third stages feed logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
      s3_ff <= 3'h1;
    end else begin
      s1_ff <= {link.clock_source_select, link.external_shift_clock,
                link.convert_start_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Edges and levels of the synchronised pins
  // (R12) falling start edge
  assign start_edge = s3_ff[0] && !s2_ff[0];
  assign start_moved = s3_ff[0] ^ s2_ff[0];
  assign xclk_moved = s3_ff[1] ^ s2_ff[1];
  // (R11) select low is master
  assign master_mode = !s2_ff[2];
  // (R5) quiet window watch
  assign in_quiet = cyc_ff >= sar_link_pkg::convert_start_n_cnt_t'(`QUIET_START_CYC);

  // Trial value for the bit under test
  always_comb begin
    mask = sar_link_pkg::sample_t'(12'h001 << idx_ff);
    base = sar_ff;
    // (R3) one-step repair at tenth
    if (idx_ff == sar_link_pkg::bit_idx_t'(`SAR_CORRECT_BIT)) begin
      if ({1'b0, sar_ff} > {1'b0, sample_ff}) begin
        base = sar_ff - `SAR_CORRECT_STEP;
      end else if ({1'b0, sample_ff} >=
                   {1'b0, sar_ff} + `SAR_CORRECT_SPAN) begin
        base = sar_ff + `SAR_CORRECT_STEP;
      end
    end
    // (R2) set, compare, maybe clear
    trial = base | mask;
    keep = (trial <= sample_ff) ^ decision_upset; // Upset models noise
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    nxt_step = step_ff;
    nxt_idx = idx_ff;
    nxt_deciding = deciding_ff;
    nxt_sar = sar_ff;
    nxt_sample = sample_ff;
    nxt_result = result_ff;
    nxt_busy = busy_ff;
    nxt_valid = 1'b0;
    nxt_disturbed = disturbed_ff;
    case (state_ff)
      sar_link_pkg::CONVERT_START_N_IDLE: begin
        // (R12) start only when powered
        if (start_edge && !power_down) begin
          nxt_state = sar_link_pkg::CONVERT_START_N_RUN;
          nxt_cyc = '0;
          nxt_step = sar_link_pkg::convert_start_n_cnt_t'(`FIRST_DECISION_CYC - 1);
          nxt_idx = sar_link_pkg::bit_idx_t'(`SAR_MSB);
          nxt_deciding = 1'b1;
          nxt_sar = '0;
          nxt_sample = analog_level; // Sample and hold
          nxt_busy = 1'b0;
          nxt_disturbed = 1'b0;
        end
      end
      sar_link_pkg::CONVERT_START_N_RUN: begin
        nxt_cyc = cyc_ff + 8'h01;
        // (R5) flag pin moves
        if (in_quiet && (start_moved || xclk_moved)) begin
          nxt_disturbed = 1'b1;
        end
        // (R1) MSB to LSB stepping
        // (R4) step spacing timing
        if (deciding_ff) begin
          if (step_ff == '0) begin
            nxt_sar = keep ? trial : base;
            nxt_step = sar_link_pkg::convert_start_n_cnt_t'(`DECISION_STEP_CYC - 1);
            if (idx_ff == '0) begin
              nxt_deciding = 1'b0;
            end else begin
              nxt_idx = idx_ff - 4'h1;
            end
          end else begin
            nxt_step = step_ff - 8'h01;
          end
        end
        // (R12) busy rises with result
        if (cyc_ff == sar_link_pkg::convert_start_n_cnt_t'(`BUSY_RISE_CYC - 1)) begin
          nxt_state = sar_link_pkg::CONVERT_START_N_IDLE;
          nxt_busy = 1'b1;
          nxt_result = sar_ff;
          nxt_valid = 1'b1;
        end
      end
      default: begin
        nxt_state = sar_link_pkg::CONVERT_START_N_IDLE;
      end
    endcase
    // Own flop so the output never shows a gate
    nxt_convert_start_n = !nxt_busy;
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sar_link_pkg::CONVERT_START_N_IDLE;
      cyc_ff <= '0;
      step_ff <= '0;
      idx_ff <= '0;
      deciding_ff <= 1'b0;
      sar_ff <= `RESULT_RESET;
      sample_ff <= `RESULT_RESET;
      result_ff <= `RESULT_RESET;
      busy_ff <= 1'b1;
      valid_ff <= 1'b0;
      disturbed_ff <= 1'b0;
      convert_start_n_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      step_ff <= nxt_step;
      idx_ff <= nxt_idx;
      deciding_ff <= nxt_deciding;
      sar_ff <= nxt_sar;
      sample_ff <= nxt_sample;
      result_ff <= nxt_result;
      busy_ff <= nxt_busy;
      valid_ff <= nxt_valid;
      disturbed_ff <= nxt_disturbed;
      convert_start_n_ff <= nxt_convert_start_n;
    end
  end

  // Shifter next state; data changes only while the clock is low
  always_comb begin
    nxt_shift = shift_ff;
    nxt_left = left_ff;
    nxt_phase = phase_ff;
    nxt_sclk = sclk_ff;
    nxt_sdo = sdo_ff;
    // (R7) start with busy fall
    if (state_ff == sar_link_pkg::CONVERT_START_N_IDLE && nxt_busy == 1'b0) begin
      if (master_mode) begin
        nxt_shift = result_ff;
        nxt_left = sar_link_pkg::bit_idx_t'(`SAR_BITS);
        nxt_phase = '0;
        nxt_sdo = result_ff[`SAR_MSB];
      end
    end else if (left_ff != '0) begin
      nxt_phase = phase_ff + 2'h1;
      if (phase_ff == 2'(`SCLK_HALF_CYC - 1)) begin
        nxt_sclk = 1'b1;
      end else if (phase_ff == 2'(2 * `SCLK_HALF_CYC - 1)) begin
        // (R9) clock back low
        nxt_sclk = 1'b0;
        nxt_phase = '0;
        nxt_left = left_ff - 4'h1;
        nxt_shift = {shift_ff[10:0], 1'b0};
        nxt_sdo = (left_ff == 4'h1) ? 1'b0 : shift_ff[10];
      end
    end
  end

  // Shifter registers; clock held low from reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= `RESULT_RESET;
      left_ff <= '0;
      phase_ff <= '0;
      sclk_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      left_ff <= nxt_left;
      phase_ff <= nxt_phase;
      sclk_ff <= nxt_sclk;
      sdo_ff <= nxt_sdo;
    end
  end

  // Outputs straight from flops
  assign link.busy = busy_ff;
  assign link.serial_clock = sclk_ff;
  assign link.serial_result_out = sdo_ff;
  assign result = result_ff;
  assign result_valid = valid_ff;
  assign link_disturbed = disturbed_ff;
  assign converting = convert_start_n_ff;

endmodule

// [verilog/sar_host.sv]
// Host end: start pulse and 12-bit serial slave receiver
`timescale 1ns/1ps
`include "sar_link_defs.svh"
module sar_host (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link pins
  sar_link_if.host link,
  // User side
  input wire logic trigger,
  output logic ready,
  output sar_link_pkg::sample_t word,
  output logic word_valid,
  output logic convert_start_n_done
);

  // Pin synchronisers: {data, serial clock, busy}
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;

  // Start pulse state
  sar_link_pkg::host_state_e state_ff, nxt_state;
  sar_link_pkg::convert_start_n_cnt_t cnt_ff, nxt_cnt;
  logic convert_start_n_n_ff, nxt_convert_start_n_n;
  logic ready_ff, nxt_ready;
  logic done_ff, nxt_done;

  // Receiver state
  sar_link_pkg::sample_t rx_ff, nxt_rx;
  sar_link_pkg::bit_idx_t got_ff, nxt_got;
  sar_link_pkg::sample_t word_ff, nxt_word;
  logic wvalid_ff, nxt_wvalid;

  logic busy_fall;
  logic busy_rise;
  logic sclk_rise;

  // Only the second and third stages feed logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
      s3_ff <= 3'h1;
    end else begin
      s1_ff <= {link.serial_result_out, link.serial_clock, link.busy};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // (R8) busy acts as select
  assign busy_fall = s3_ff[0] && !s2_ff[0];
  assign busy_rise = !s3_ff[0] && s2_ff[0];
  assign sclk_rise = !s3_ff[1] && s2_ff[1];

  // Start pulse next state; the line rises long before the quiet window
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_convert_start_n_n = convert_start_n_n_ff;
    nxt_ready = 1'b0;
    nxt_done = busy_rise;
    case (state_ff)
      sar_link_pkg::HOST_IDLE: begin
        nxt_ready = s2_ff[0];
        // (R10) user trigger drives start
        if (trigger && s2_ff[0]) begin
          nxt_state = sar_link_pkg::HOST_PULSE;
          nxt_convert_start_n_n = 1'b0;
          nxt_cnt = sar_link_pkg::convert_start_n_cnt_t'(`CONVERT_START_N_LOW_CYC - 1);
          nxt_ready = 1'b0;
        end
      end
      sar_link_pkg::HOST_PULSE: begin
        // (R6) return high early
        if (cnt_ff == '0) begin
          nxt_state = sar_link_pkg::HOST_WAIT;
          nxt_convert_start_n_n = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      sar_link_pkg::HOST_WAIT: begin
        // (R5) stay still until busy
        if (busy_rise) begin
          nxt_state = sar_link_pkg::HOST_IDLE;
        end
      end
      default: begin
        nxt_state = sar_link_pkg::HOST_IDLE;
      end
    endcase
  end

  // Start pulse registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sar_link_pkg::HOST_IDLE;
      cnt_ff <= '0;
      convert_start_n_n_ff <= 1'b1;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      convert_start_n_n_ff <= nxt_convert_start_n_n;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
    end
  end

  // Receiver: sample data on the rising serial clock edge
  always_comb begin
    nxt_rx = rx_ff;
    nxt_got = got_ff;
    nxt_word = word_ff;
    nxt_wvalid = 1'b0;
    // (R8) twelve bits per frame
    if (busy_fall) begin
      nxt_got = '0;
    end else if (sclk_rise && !s2_ff[0] &&
                 got_ff != sar_link_pkg::bit_idx_t'(`SAR_BITS)) begin
      nxt_rx = {rx_ff[10:0], s2_ff[2]};
      nxt_got = got_ff + 4'h1;
      if (got_ff == sar_link_pkg::bit_idx_t'(`SAR_BITS - 1)) begin
        nxt_word = {rx_ff[10:0], s2_ff[2]};
        nxt_wvalid = 1'b1;
      end
    end
  end

  // Receiver registers; an idle receiver counts as full
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_ff <= `RESULT_RESET;
      got_ff <= 4'hC;
      word_ff <= `RESULT_RESET;
      wvalid_ff <= 1'b0;
    end else begin
      rx_ff <= nxt_rx;
      got_ff <= nxt_got;
      word_ff <= nxt_word;
      wvalid_ff <= nxt_wvalid;
    end
  end

  // Outputs; shift clock and select are held static low for master mode
  // (R11) select tied low
  assign link.clock_source_select = 1'b0;
  assign link.external_shift_clock = 1'b0;
  assign link.convert_start_n = convert_start_n_n_ff;
  assign ready = ready_ff;
  assign word = word_ff;
  assign word_valid = wvalid_ff;
  assign convert_start_n_done = done_ff;

endmodule

// [tb/sar_link_monitor.sv]
// Checker on the converter-host link pins
`timescale 1ns/1ps
module sar_link_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link pins
  input wire logic convert_start_n,
  input wire logic external_shift_clock,
  input wire logic clock_source_select,
  input wire logic busy,
  input wire logic serial_clock,
  input wire logic serial_result_out
);
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  logic [3:0] pulse_cnt_ff;
  logic [3:0] nxt_pulse_cnt;
  logic sclk_q_ff;

  // Busy-low cycles and clock pulses of the current frame
  always_comb begin
    nxt_low_cnt = busy ? 8'h00 : low_cnt_ff + 8'h01;
    nxt_pulse_cnt = busy ? 4'h0 :
      pulse_cnt_ff + {3'h0, serial_clock & ~sclk_q_ff};
  end

  // Counters restart with reset so a stale frame never counts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_ff <= 8'h00;
      pulse_cnt_ff <= 4'h0;
      sclk_q_ff <= 1'b0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
      pulse_cnt_ff <= nxt_pulse_cnt;
      sclk_q_ff <= serial_clock;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_START_TAKEN: assert property (
    $fell(convert_start_n) && busy |-> ##[2:4] !busy)
    else $error("busy did not fall after start");
  AST_BUSY_SPAN: assert property (
    $rose(busy) |-> low_cnt_ff == 8'h82)
    else $error("busy low span wrong");
  AST_CLOCK_START: assert property (
    $fell(busy) && !clock_source_select |->
      !serial_clock [*2] ##1 serial_clock)
    else $error("serial clock did not start on busy fall");
  AST_CLOCK_HIGH: assert property (
    $rose(serial_clock) |-> serial_clock [*2] ##1 !serial_clock)
    else $error("serial clock high phase wrong");
  AST_DATA_STEADY: assert property (
    $rose(serial_clock) |-> $stable(serial_result_out))
    else $error("data moved at clock rise");
  AST_TWELVE_PULSES: assert property (
    $rose(busy) && !clock_source_select |-> pulse_cnt_ff == 4'hC)
    else $error("frame pulse count wrong");
  AST_IDLE_LOW: assert property (
    busy || low_cnt_ff > 8'h32 |-> !serial_clock)
    else $error("serial clock not idle low");
  AST_QUIET_WINDOW: assert property (
    !busy && low_cnt_ff >= 8'h50 |->
      $stable(convert_start_n) && $stable(external_shift_clock))
    else $error("host input moved in quiet window");
  AST_START_RELEASE: assert property (
    $fell(convert_start_n) |->
      !convert_start_n [*8] ##[1:4] convert_start_n)
    else $error("start line not released early");

  // Main scenarios
  COV_FRAME: cover property ($rose(busy));
  COV_PULSE: cover property ($rose(serial_clock));
  COV_START: cover property ($fell(convert_start_n));
endmodule

// [tb/testbench.sv]
// Self-checking bench: converter and host joined by the link
`timescale 1ns/1ps
`include "sar_link_defs.svh"
module testbench;
  logic clock;
  logic arst_n;
  logic trigger;
  logic decision_upset;
  logic power_down_2;
  sar_link_pkg::sample_t analog_level, result, result_2, word;
  sar_link_pkg::sample_t prev, wire_bits, word_seen;
  logic result_valid, result_valid_2, link_disturbed, link_disturbed_2;
  logic converting, converting_2, ready, word_valid, convert_start_n_done;
  int miscompares, checked, wire_n;
  logic [11:0] lv [8] = '{12'h000, 12'hFFF, 12'hA5C, 12'h800, 12'h7FF,
    12'h002, 12'h003, 12'h007};
  logic [11:0] ex [8] = '{12'h000, 12'hFFF, 12'hA5C, 12'h800, 12'h7FF,
    12'h001, 12'h002, 12'h007};
  // Last entry: wrong bit 3 that the tenth decision repairs
  int up [8] = '{0, 0, 0, 0, 0, 110, 120, 90};

  sar_link_if link();
  sar_link_if link_2();

  sar_converter u_sar_converter (.clock(clock), .arst_n(arst_n),
    .link(link.converter), .analog_level(analog_level),
    .power_down(1'b0), .decision_upset(decision_upset), .result(result),
    .result_valid(result_valid), .link_disturbed(link_disturbed),
    .converting(converting));
  sar_host u_sar_host (.clock(clock), .arst_n(arst_n), .link(link.host),
    .trigger(trigger), .ready(ready), .word(word),
    .word_valid(word_valid), .convert_start_n_done(convert_start_n_done));
  // Second converter faces the bench, which breaks host rules on purpose
  sar_converter u_sar_converter_rogue (.clock(clock), .arst_n(arst_n),
    .link(link_2.converter), .analog_level(12'h5A5),
    .power_down(power_down_2), .decision_upset(1'b0),
    .result(result_2), .result_valid(result_valid_2),
    .link_disturbed(link_disturbed_2), .converting(converting_2));
  sar_link_monitor u_sar_link_monitor (.clock(clock), .arst_n(arst_n),
    .convert_start_n(link.convert_start_n),
    .external_shift_clock(link.external_shift_clock),
    .clock_source_select(link.clock_source_select), .busy(link.busy),
    .serial_clock(link.serial_clock),
    .serial_result_out(link.serial_result_out));

  // Clock source
  initial begin
    clock = 1'b0;
    forever #(`CLK_PERIOD_NS / 2) clock = ~clock;
  end

  // Wire capture on clock rise, new frame on busy fall
  always @(negedge link.busy) wire_n = 0;
  always @(posedge link.serial_clock) begin
    wire_bits = {wire_bits[10:0], link.serial_result_out};
    wire_n++;
  end
  // Word pulse lasts one cycle, so latch it here
  always @(posedge clock) if (word_valid) word_seen <= word;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Host-driven conversion, optional upset window from cycle upset_at
  task automatic host_convert_start_n(input logic [11:0] level, input int upset_at,
      input logic [11:0] exp);
    int low;
    int i;
    int dones;
    low = 0;
    dones = 0;
    analog_level = level;
    trigger = 1'b1;
    @(negedge clock);
    trigger = 1'b0;
    for (i = 0; i < 20 && link.busy; i++) @(negedge clock);
    check(converting, 1'b1);
    if (upset_at > 0) begin
      repeat (upset_at) @(negedge clock);
      decision_upset = 1'b1;
      repeat (8) @(negedge clock);
      decision_upset = 1'b0;
      low = upset_at + 8;
    end
    for (i = 0; i < 200 && !result_valid; i++) begin
      if (!link.busy) low++;
      @(negedge clock);
    end
    check(result_valid, 1'b1);
    check(converting, 1'b0);
    check(link_disturbed, 1'b0);
    check(result, exp);
    check(low, 130);
    check(word_seen, prev);
    check(wire_bits, prev);
    check(wire_n, 12);
    check(link.serial_clock, 1'b0);
    for (i = 0; i < 10 && !ready; i++) begin
      dones += convert_start_n_done;
      @(negedge clock);
    end
    check(ready, 1'b1);
    check(dones, 1);
    check(result_valid, 1'b0);
    prev = exp;
  endtask

  // Bench-driven start on the second link
  task automatic rogue_convert_start_n(input logic pd, input logic sel,
      input logic glitch);
    int low;
    int rises;
    int i;
    logic sclk_q;
    int vals;
    logic [11:0] bits;
    low = 0;
    rises = 0;
    sclk_q = 1'b0;
    vals = 0;
    bits = 12'h000;
    power_down_2 = pd;
    link_2.clock_source_select = sel;
    link_2.external_shift_clock = 1'b0;
    link_2.convert_start_n = 1'b0;
    for (i = 0; i < 220; i++) begin
      @(negedge clock);
      if (i == 10) link_2.convert_start_n = 1'b1;
      if (!link_2.busy) low++;
      if (link_2.serial_clock && !sclk_q) begin
        rises++;
        bits = {bits[10:0], link_2.serial_result_out};
      end
      if (result_valid_2) vals++;
      sclk_q = link_2.serial_clock;
      if (glitch && low == 85) link_2.external_shift_clock = 1'b1;
    end
    check(low, pd ? 0 : 130);
    check(rises, (pd || sel) ? 0 : 12);
    check(link_disturbed_2, glitch);
    check(result_2, pd ? 12'h000 : 12'h5A5);
    check(bits, (pd || sel) ? 12'h000 : 12'h5A5);
    check(vals, pd ? 0 : 1);
    check(converting_2, 1'b0);
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    trigger = 1'b0;
    decision_upset = 1'b0;
    analog_level = 12'h000;
    power_down_2 = 1'b0;
    word_seen = 12'hFFF;
    prev = `RESULT_RESET;
    link_2.convert_start_n = 1'b1;
    link_2.external_shift_clock = 1'b0;
    link_2.clock_source_select = 1'b0;
    miscompares = 0;
    checked = 0;
    wire_n = 0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    for (int k = 0; k < 8; k++) host_convert_start_n(lv[k], up[k], ex[k]);
    rogue_convert_start_n(1'b1, 1'b0, 1'b0);
    rogue_convert_start_n(1'b0, 1'b1, 1'b1);
    rogue_convert_start_n(1'b0, 1'b0, 1'b0);
    end_of_test();
  end

  // Watchdog, well past the expected run
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
endmodule
